// File: rtl/sc_pkg.sv
// Constants and types shared by the sensor control core and its serial port.
// Assumes a core clock and a serial link clock.
// Overview of operation
// R1 - Trim reload bit copies nonvolatile trim in
// R2 - Hardware clears trim reload bit when done
// R3 - Trim reload starts one rate tick later
// R4 - Power-up loads trim before normal operation
// R5 - Polarity bit selects event pin active level
// R6 - Drive bit selects push-pull or open-drain
// R7 - Auto-increment advances address after each byte
// R8 - Soft reset restores defaults then self-clears
// R9 - Low-noise forced off at 100/200 Hz
// R10 - Host changes low-noise only in power-down; the core takes LN bit writes at any rate
// R11 - Single-shot write at rate 000 measures once
// R12 - Single-shot completion self-clears the bit
// R13 - Full event routed at 128 unread samples
// R14 - Level event routed while level reaches threshold
// R15 - Overrun event routed after sample overwritten
// R16 - Data-ready routing gate; routing resets zero
// R17 - Two-bit select picks data, high, low, either
// R18 - Untriggered mode field: bypass, fifo, continuous
// R19 - Triggered mode field gives three triggered modes
// R20 - Stop-at-level makes watermark count mean full; the core matches the level against thr_reg[4:0] only
// R21 - FIFO output bytes readable at consecutive addresses
// R22 - Reference pressure is 16-bit, low and high
// R23 - Reference stored and used by auto functions
// R24 - Rate 000 is power-down, keeps configuration
// R25 - Polarity zero active-high, one active-low, default zero
// R26 - Auto-increment bit resets to one
// R27 - Unused routing and FIFO bits read zero

package sc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] SC_ADDR_RATE = 7'h10;
  localparam logic [6:0] SC_ADDR_CTRL = 7'h11;
  localparam logic [6:0] SC_ADDR_ROUTE = 7'h12;
  localparam logic [6:0] SC_ADDR_FIFO = 7'h13;
  localparam logic [6:0] SC_ADDR_THR = 7'h14;
  localparam logic [6:0] SC_ADDR_REF_LOW_BITS = 7'h15;
  localparam logic [6:0] SC_ADDR_REFH = 7'h16;
  localparam logic [6:0] SC_ADDR_FDAT = 7'h78;
  localparam logic [6:0] SC_ADDR_FEND = 7'h7C;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int SC_RATE_LSB = 4;
  localparam int SC_BIT_BOOT = 7;
  localparam int SC_BIT_POL = 6;
  localparam int SC_BIT_DRV = 5;
  localparam int SC_BIT_INC = 4;
  localparam int SC_BIT_SRST = 2;
  localparam int SC_BIT_LN = 1;
  localparam int SC_BIT_ONE = 0;
  localparam logic [7:0] SC_MASK_ROUTE = 8'h3F;
  localparam logic [7:0] SC_MASK_FIFO = 8'h0F;
  localparam logic [7:0] SC_MASK_THR = 8'h7F;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] SC_RATE_RST = 3'h0;
  localparam logic [2:0] SC_RATE_100HZ = 3'h6;
  localparam logic [7:0] SC_CTRL_RST = 8'h10;
  localparam logic [7:0] SC_ZERO_RST = 8'h00;
  localparam logic [7:0] SC_FIFO_FULL_CNT = 8'h80;
  localparam int SC_TRIM_WORDS = 8;
  localparam int SC_SNAP_BYTES = 12;
  localparam int SC_SNAP_FIFO = 7;

  // FIFO operating modes, one-hot.
  typedef enum logic [5:0] {
    SC_FM_BYPASS = 6'b000001,
    SC_FM_FIFO = 6'b000010,
    SC_FM_CONT = 6'b000100,
    SC_FM_BYP2FIFO = 6'b001000,
    SC_FM_BYP2CONT = 6'b010000,
    SC_FM_CONT2FIFO = 6'b100000
  } sc_fifo_mode_t;

  // Trim loader states, one-hot.
  typedef enum logic [2:0] {
    SC_TR_IDLE = 3'b001,
    SC_TR_WAIT = 3'b010,
    SC_TR_COPY = 3'b100
  } sc_trim_state_t;

endpackage

// File: rtl/sc_link.sv
// Serial register port: frame logic clocked by the host's serial clock.
// Assumes chip select frames each access and the clock rests between frames.
`timescale 1ns/1ps

module sc_link
  import sc_pkg::*;
(
  input wire logic spi_clk, // Serial clock from the host.
  input wire logic spi_cs_n, // Chip select, active low.
  input wire logic spi_mosi, // Serial data in.
  output logic spi_miso, // Serial data out.
  input wire logic rst_n, // Core reset, used as an async clear here.
  input wire logic [8*sc_pkg::SC_SNAP_BYTES-1:0] snap, // Read image.
  output logic [6:0] wr_addr, // Held address of the last write.
  output logic [7:0] wr_data, // Held data of the last write.
  output logic wr_tgl // Toggles once per written byte.
);
  import sc_pkg::*;

  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic [6:0] addr_reg;
  logic first_reg;
  logic rd_reg;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;

  // --------------------------------------------------------------
  // Read image lookup
  // --------------------------------------------------------------
  // Maps a register address to its byte of the frozen read image.
  function automatic logic [7:0] pick(input logic [6:0] a,
                                      input logic [95:0] img);
    logic [6:0] idx;
    idx = 7'h7F;
    if (a >= SC_ADDR_RATE && a <= SC_ADDR_REFH)
      idx = a - SC_ADDR_RATE;
    else if (a >= SC_ADDR_FDAT && a <= SC_ADDR_FEND)
      idx = a - SC_ADDR_FDAT + 7'(SC_SNAP_FIFO);
    if (idx == 7'h7F)
      pick = 8'h00;
    else
      pick = img[idx[3:0]*8 +: 8];
  endfunction

  assign byte_in = {shift_reg, spi_mosi};
  assign rd_byte = pick(addr_reg, snap);

  // --------------------------------------------------------------
  // Frame decoding
  // --------------------------------------------------------------
  // Chip select high clears the bit count of a broken frame.
  always_ff @(posedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      addr_reg <= 7'h00;
      first_reg <= 1'b1;
      rd_reg <= 1'b0;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= byte_in[6:0];
      if (bit_cnt_reg == 3'h7)
      begin
        if (first_reg)
        begin
          first_reg <= 1'b0;
          rd_reg <= byte_in[7];
          addr_reg <= byte_in[6:0];
        end
        else if (snap[8*1 + SC_BIT_INC])
          addr_reg <= addr_reg + 7'h01; // R7 R21
      end
    end
  end

  // A toggle hands each written byte over; only core reset clears it.
  always_ff @(posedge spi_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
      wr_tgl <= 1'b0;
    end
    else if (!spi_cs_n && bit_cnt_reg == 3'h7 && !first_reg && !rd_reg)
    begin
      wr_addr <= addr_reg;
      wr_data <= byte_in;
      wr_tgl <= ~wr_tgl;
    end
  end

  // Output data moves on the falling edge, half a bit early.
  always_ff @(negedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      spi_miso <= 1'b0;
    else if (rd_reg && !first_reg)
      spi_miso <= rd_byte[3'h7 - bit_cnt_reg]; // R21
    else
      spi_miso <= 1'b0;
  end

endmodule

// File: rtl/sc_core.sv
// Sensor control core: configuration registers, trim loading, single-shot
// control, event pin routing and FIFO mode decoding.
// Assumes the measurement, FIFO storage and trim memory sit on core_clk.
`timescale 1ns/1ps

module sc_core
  import sc_pkg::*;
(
  input wire logic core_clk, // Core clock, 20 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic spi_clk, // Serial clock from the host.
  input wire logic spi_cs_n, // Chip select, active low.
  input wire logic spi_mosi, // Serial data in.
  output logic spi_miso, // Serial data out.
  input wire logic rate_tick, // One pulse per output data rate cycle.
  output logic [2:0] sample_rate_sel, // Active rate code.
  output logic meas_run, // Continuous acquisition enabled.
  output logic meas_start, // Single-shot start pulse.
  input wire logic meas_done, // Measurement complete pulse.
  output logic low_noise_on, // Effective low-noise mode.
  output logic [2:0] trim_mem_addr, // Trim memory address.
  input wire logic [7:0] trim_mem_data, // Trim memory data, 1 cycle late.
  input wire logic [2:0] trim_sel, // Trim word to show.
  output logic [7:0] trim_value, // Selected trim word.
  output logic trim_ready, // Trim content loaded.
  input wire logic data_ready, // Data-ready level.
  input wire logic [7:0] fifo_level, // Unread samples in the FIFO.
  input wire logic fifo_overrun, // A stored sample was overwritten.
  input wire logic press_high, // Pressure high event.
  input wire logic press_low, // Pressure low event.
  input wire logic [23:0] fifo_press, // Pressure at the FIFO head.
  input wire logic [15:0] fifo_temp, // Temperature at the FIFO head.
  output sc_pkg::sc_fifo_mode_t fifo_mode, // Decoded FIFO mode.
  output logic fifo_full, // FIFO treated as full.
  input wire logic ref_load, // Capture reference pressure pulse.
  input wire logic [15:0] ref_in, // Pressure to capture as reference.
  input wire logic auto_null_func, // Auto_null_func function enabled.
  input wire logic auto_ref_func, // Automatic reference enabled.
  output logic [15:0] ref_pressure, // Stored reference pressure.
  output logic ref_apply, // Reference in use.
  output logic event_pin_o, // Event pin output level.
  output logic event_pin_oe, // Event pin output enable.
  output logic [1:0] event_src // Highest priority active data event.
);
  import sc_pkg::*;

  logic [2:0] rate_reg;
  logic pol_reg, drv_reg, inc_reg, ln_reg, one_reg, srst_reg, boot_req_reg;
  logic [7:0] route_reg;
  logic [7:0] fifoctl_reg;
  logic [7:0] thr_reg;
  logic [15:0] ref_reg;
  sc_trim_state_t trim_st_reg;
  sc_trim_state_t trim_st_next;
  logic [2:0] trim_idx_reg;
  logic trim_cap_reg;
  logic [2:0] trim_cap_idx_reg;
  logic [7:0] trim_mem [SC_TRIM_WORDS];
  logic busy_reg, cs_s1_reg, cs_s2_reg, tg_s1_reg, tg_s2_reg, tg_s3_reg;
  logic [95:0] snap_reg;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_tgl;
  logic wr_evt, vol_clr, wtm_hit, full_hit, data_sig, pin_act, pin_lvl;
  logic [7:0] ctrl_byte;

  // --------------------------------------------------------------
  // Serial port and crossings
  // --------------------------------------------------------------
  sc_link u_link (
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .rst_n(rst_n),
    .snap(snap_reg),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_tgl(wr_tgl)
  );

  // Chip select and the write toggle arrive from the link domain.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      tg_s3_reg <= 1'b0;
    end
    else
    begin
      cs_s1_reg <= spi_cs_n;
      cs_s2_reg <= cs_s1_reg;
      tg_s1_reg <= wr_tgl;
      tg_s2_reg <= tg_s1_reg;
      tg_s3_reg <= tg_s2_reg;
    end
  end

  // Address and data settle long before the toggle; no synchroniser.
  assign wr_evt = tg_s2_reg ^ tg_s3_reg;
  assign vol_clr = !rst_n || srst_reg; // R8

  assign ctrl_byte = {boot_req_reg || (trim_st_reg != SC_TR_IDLE),
                      pol_reg, drv_reg, inc_reg, 1'b0, srst_reg,
                      ln_reg, one_reg};

  // The read image freezes two cycles after chip select falls.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      snap_reg <= 96'h0;
    else if (cs_s2_reg)
      snap_reg <= {fifo_temp, fifo_press, ref_reg,
                   thr_reg, fifoctl_reg, route_reg, ctrl_byte,
                   1'b0, rate_reg, 4'h0}; // R21 R22
  end

  // --------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------
  // Rate and control bits; a soft reset returns them to defaults.
  always_ff @(posedge core_clk)
  begin
    if (vol_clr)
    begin
      rate_reg <= SC_RATE_RST;
      pol_reg <= SC_CTRL_RST[SC_BIT_POL]; // R25
      drv_reg <= SC_CTRL_RST[SC_BIT_DRV];
      inc_reg <= SC_CTRL_RST[SC_BIT_INC]; // R26
      ln_reg <= SC_CTRL_RST[SC_BIT_LN];
    end
    else if (wr_evt && wr_addr == SC_ADDR_RATE)
      rate_reg <= wr_data[SC_RATE_LSB +: 3];
    else if (wr_evt && wr_addr == SC_ADDR_CTRL)
    begin
      pol_reg <= wr_data[SC_BIT_POL]; // R5
      drv_reg <= wr_data[SC_BIT_DRV]; // R6
      inc_reg <= wr_data[SC_BIT_INC]; // R7
      ln_reg <= wr_data[SC_BIT_LN];
    end
  end

  // Soft reset lasts one cycle, then clears itself.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      srst_reg <= 1'b0;
    else
      srst_reg <= wr_evt && wr_addr == SC_ADDR_CTRL &&
                  wr_data[SC_BIT_SRST] && !srst_reg; // R8
  end

  // Routing, FIFO control and threshold; unused bits never store.
  always_ff @(posedge core_clk)
  begin
    if (vol_clr)
    begin
      route_reg <= SC_ZERO_RST; // R16
      fifoctl_reg <= SC_ZERO_RST;
      thr_reg <= SC_ZERO_RST;
    end
    else if (wr_evt)
    begin
      if (wr_addr == SC_ADDR_ROUTE)
        route_reg <= wr_data & SC_MASK_ROUTE; // R27
      if (wr_addr == SC_ADDR_FIFO)
        fifoctl_reg <= wr_data & SC_MASK_FIFO; // R27
      if (wr_addr == SC_ADDR_THR)
        thr_reg <= wr_data & SC_MASK_THR;
    end
  end

  // Reference pressure is filled by the pressure path, not by writes.
  always_ff @(posedge core_clk)
  begin
    if (vol_clr)
      ref_reg <= 16'h0000;
    else if (ref_load)
      ref_reg <= ref_in; // R22 R23
  end

  assign ref_pressure = ref_reg;
  assign ref_apply = auto_null_func || auto_ref_func; // R23

  // --------------------------------------------------------------
  // Rate, low-noise and single-shot control
  // --------------------------------------------------------------
  assign sample_rate_sel = rate_reg;
  assign meas_run = (rate_reg != 3'h0) && trim_ready; // R24 R4
  assign low_noise_on = ln_reg && (rate_reg < SC_RATE_100HZ); // R9

  // Single-shot is taken in power-down only and held until done.
  always_ff @(posedge core_clk)
  begin
    if (vol_clr)
    begin
      one_reg <= 1'b0;
      busy_reg <= 1'b0;
      meas_start <= 1'b0;
    end
    else
    begin
      meas_start <= 1'b0;
      if (one_reg && !busy_reg && trim_ready)
      begin
        busy_reg <= 1'b1;
        meas_start <= 1'b1; // R11
      end
      else if (busy_reg && meas_done)
      begin
        busy_reg <= 1'b0;
        one_reg <= 1'b0; // R12
      end
      if (wr_evt && wr_addr == SC_ADDR_CTRL && wr_data[SC_BIT_ONE] &&
          rate_reg == 3'h0 && !one_reg)
        one_reg <= 1'b1; // R11 R24
    end
  end

  // --------------------------------------------------------------
  // Trim loader
  // --------------------------------------------------------------
  // A reload request waits for the next rate tick before copying.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      boot_req_reg <= 1'b0;
    else if (wr_evt && wr_addr == SC_ADDR_CTRL && wr_data[SC_BIT_BOOT])
      boot_req_reg <= 1'b1; // R1
    else if (trim_st_reg == SC_TR_WAIT)
      boot_req_reg <= 1'b0;
  end

  always_comb
  begin
    trim_st_next = trim_st_reg;
    case (trim_st_reg)
      SC_TR_IDLE:
        if (boot_req_reg)
          trim_st_next = SC_TR_WAIT;
      SC_TR_WAIT:
        if (rate_tick)
          trim_st_next = SC_TR_COPY; // R3
      SC_TR_COPY:
        if (trim_cap_reg && trim_cap_idx_reg == 3'(SC_TRIM_WORDS - 1))
          trim_st_next = SC_TR_IDLE; // R2
      default:
        trim_st_next = SC_TR_IDLE;
    endcase
  end

  // Reset starts in the copy state so trim is loaded at power-up.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      trim_st_reg <= SC_TR_COPY; // R4
      trim_idx_reg <= 3'h0;
      trim_cap_reg <= 1'b0;
      trim_cap_idx_reg <= 3'h0;
    end
    else
    begin
      trim_st_reg <= trim_st_next;
      trim_cap_reg <= (trim_st_reg == SC_TR_COPY) &&
                      (trim_st_next == SC_TR_COPY);
      trim_cap_idx_reg <= trim_idx_reg;
      if (trim_st_reg == SC_TR_COPY)
        trim_idx_reg <= trim_idx_reg + 3'h1;
      else
        trim_idx_reg <= 3'h0;
    end
  end

  // Trim words land one cycle after their address goes out.
  always_ff @(posedge core_clk)
  begin
    if (trim_cap_reg)
      trim_mem[trim_cap_idx_reg] <= trim_mem_data; // R1 R4
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      trim_value <= 8'h00;
    else
      trim_value <= trim_mem[trim_sel];
  end

  assign trim_mem_addr = trim_idx_reg;
  assign trim_ready = (trim_st_reg != SC_TR_COPY);

  // --------------------------------------------------------------
  // FIFO mode and flags
  // --------------------------------------------------------------
  always_comb
  begin
    case (fifoctl_reg[2:0])
      3'b000, 3'b100:
        fifo_mode = SC_FM_BYPASS; // R18
      3'b001:
        fifo_mode = SC_FM_FIFO; // R18
      3'b010, 3'b011:
        fifo_mode = SC_FM_CONT; // R18
      3'b101:
        fifo_mode = SC_FM_BYP2FIFO; // R19
      3'b110:
        fifo_mode = SC_FM_BYP2CONT; // R19
      3'b111:
        fifo_mode = SC_FM_CONT2FIFO; // R19
      default:
        fifo_mode = SC_FM_BYPASS;
    endcase
  end

  assign wtm_hit = fifo_level >= {1'b0, thr_reg[6:0]}; // R14
  assign full_hit = (fifo_level >= SC_FIFO_FULL_CNT) ||
                    (fifoctl_reg[3] &&
                     fifo_level == {3'h0, thr_reg[4:0]}); // R13 R20
  assign fifo_full = full_hit;

  // --------------------------------------------------------------
  // Event pin
  // --------------------------------------------------------------
  // Data events are ORed; the source code reports the strongest one.
  assign data_sig = (route_reg[2] && data_ready) || // R16
                    (route_reg[4] && wtm_hit) || // R14
                    (route_reg[3] && fifo_overrun) || // R15
                    (route_reg[5] && full_hit); // R13

  always_comb
  begin
    case (route_reg[0 +: 2])
      2'b00: pin_act = data_sig; // R17
      2'b01: pin_act = press_high; // R17
      2'b10: pin_act = press_low; // R17
      default: pin_act = press_high || press_low; // R17
    endcase
  end

  assign pin_lvl = pin_act ^ pol_reg; // R5 R25

  // Open-drain only ever pulls low, so it is enabled for a low level.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      event_pin_o <= 1'b0;
      event_pin_oe <= 1'b1;
      event_src <= 2'h0;
    end
    else
    begin
      event_pin_o <= drv_reg ? 1'b0 : pin_lvl; // R6
      event_pin_oe <= drv_reg ? !pin_lvl : 1'b1; // R6
      event_src <= (route_reg[2] && data_ready) ? 2'h0 :
                   (route_reg[4] && wtm_hit) ? 2'h1 :
                   (route_reg[3] && fifo_overrun) ? 2'h2 : 2'h3; // R17
    end
  end

endmodule

// File: tb/sc_host_model.sv
// Host end of the serial register port; drives whole frames on the link.
// Assumes the core shifts miso on the falling edge of the link clock.
`timescale 1ns/1ps

module sc_host_model (
  output logic spi_clk, // Link clock, still between frames.
  output logic spi_cs_n, // Chip select, active low.
  output logic spi_mosi, // Serial data to the core.
  input wire logic spi_miso // Serial data from the core.
);
  // Idle levels at time zero.
  initial
  begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end

  // One byte, MSB first, 12 ns link period, sampled on the rising edge.
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      #6;
      spi_clk = 1'b1;
      rx[i] = spi_miso;
      #6;
      spi_clk = 1'b0;
    end
  endtask

  // One data byte per write, five per read; the tail lets writes land.
  task automatic frame(input logic [7:0] hdr, input logic [7:0] wd,
    output logic [39:0] rd);
    logic [7:0] b;
    rd = '0;
    spi_cs_n = 1'b0;
    #200;
    shift(hdr, b);
    if (hdr[7])
    begin
      for (int n = 0; n < 5; n++)
      begin
        shift(8'h5A, b);
        rd = {rd[31:0], b};
      end
    end
    else
      shift(wd, b);
    spi_mosi = ~spi_mosi;
    #6;
    spi_cs_n = 1'b1;
    #300;
  endtask
endmodule

// File: tb/sc_core_props.sv
// Concurrent checks on the ports of the sensor control core.
// Assumes one core clock domain; bound into every core instance.
`timescale 1ns/1ps

module sc_core_props (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [2:0] sample_rate_sel, // Active rate code.
  input wire logic meas_run, // Continuous acquisition.
  input wire logic meas_start, // Single-shot start.
  input wire logic low_noise_on, // Effective low-noise mode.
  input wire logic trim_ready, // Trim loaded.
  input wire logic [7:0] fifo_level, // Unread samples.
  input wire logic fifo_full, // FIFO treated as full.
  input wire logic ref_load, // Reference capture pulse.
  input wire logic [15:0] ref_in, // Pressure to capture.
  input wire logic auto_null_func, // Auto_null_func enabled.
  input wire logic auto_ref_func, // Auto reference enabled.
  input wire logic [15:0] ref_pressure, // Stored reference.
  input wire logic ref_apply // Reference in use.
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // The copy is short, so twenty cycles is a generous bound.
  sequence s_trim_copy;
    !trim_ready ##[1:20] trim_ready;
  endsequence

  a_trim_boot: assert property ($rose(rst_n) |-> s_trim_copy)
    else $error("trim not loaded after reset");
  a_ln_forced_off: assert property (sample_rate_sel >= 3'h6 |-> !low_noise_on)
    else $error("low noise on at high rate");
  a_run_needs_rate: assert property (meas_run |-> sample_rate_sel != 3'h0)
    else $error("acquisition in power-down");
  a_shot_once: assert property (meas_start |=> !meas_start)
    else $error("single-shot start too long");
  a_shot_pdown: assert property (meas_start |-> sample_rate_sel == 3'h0)
    else $error("single-shot outside power-down");
  a_full_count: assert property (fifo_level >= 8'h80 |-> fifo_full)
    else $error("full not flagged at 128");
  a_ref_apply: assert property (ref_apply == (auto_null_func || auto_ref_func))
    else $error("reference use wrong");
  a_ref_store: assert property (ref_load |=> ref_pressure == $past(ref_in))
    else $error("reference not stored");
endmodule

bind sc_core sc_core_props u_props (.core_clk(core_clk), .rst_n(rst_n),
  .sample_rate_sel(sample_rate_sel), .meas_run(meas_run),
  .meas_start(meas_start), .low_noise_on(low_noise_on),
  .trim_ready(trim_ready), .fifo_level(fifo_level), .fifo_full(fifo_full),
  .ref_load(ref_load), .ref_in(ref_in), .auto_null_func(auto_null_func),
  .auto_ref_func(auto_ref_func), .ref_pressure(ref_pressure),
  .ref_apply(ref_apply));

// File: tb/sc_core_tb.sv
// Self-checking bench for the sensor control core over its serial port.
// Assumes the host model drives the link and the checker is bound in.
`timescale 1ns/1ps

module sc_core_tb;
  import sc_pkg::*;
  localparam sc_fifo_mode_t FM_EXP [8] = '{SC_FM_BYPASS, SC_FM_FIFO,
    SC_FM_CONT, SC_FM_CONT, SC_FM_BYPASS, SC_FM_BYP2FIFO, SC_FM_BYP2CONT,
    SC_FM_CONT2FIFO};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rate_tick = 1'b0;
  logic meas_done = 1'b0;
  logic ref_load = 1'b0;
  logic [1:0] auto_f = 2'h0;
  logic [15:0] ref_in = 16'h0000;
  logic [7:0] trim_mem_data = 8'h00;
  logic [7:0] trim_key = 8'h00;
  logic [11:0] ev = 12'h000; // Data ready, overrun, high, low, level.
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int shots = 0;
  wire spi_clk, spi_cs_n, spi_mosi, spi_miso, meas_start, low_noise_on;
  wire trim_ready, fifo_full, event_pin_o, event_pin_oe;
  wire [7:0] trim_value;
  wire [2:0] trim_mem_addr;
  wire [1:0] event_src;
  wire sc_fifo_mode_t fifo_mode;
  // A pull-up makes a released pin read high.
  wire pin_lvl = event_pin_oe ? event_pin_o : 1'b1;

  sc_host_model host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  sc_core dut (.core_clk(core_clk), .rst_n(rst_n), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .rate_tick(rate_tick), .sample_rate_sel(), .meas_run(),
    .meas_start(meas_start), .meas_done(meas_done),
    .low_noise_on(low_noise_on), .trim_mem_addr(trim_mem_addr),
    .trim_mem_data(trim_mem_data), .trim_sel(3'h3), .trim_value(trim_value),
    .trim_ready(trim_ready), .data_ready(ev[11]), .fifo_level(ev[7:0]),
    .fifo_overrun(ev[10]), .press_high(ev[9]), .press_low(ev[8]),
    .fifo_press(24'hC3B2A1), .fifo_temp(16'hE5D4), .fifo_mode(fifo_mode),
    .fifo_full(fifo_full), .ref_load(ref_load), .ref_in(ref_in),
    .auto_null_func(auto_f[1]), .auto_ref_func(auto_f[0]),
    .ref_pressure(), .ref_apply(), .event_pin_o(event_pin_o),
    .event_pin_oe(event_pin_oe), .event_src(event_src));

  // Core clock, 50 ns period.
  initial
    forever #25 core_clk = ~core_clk;

  // Trim memory answers one cycle late; the key alters its content.
  always @(posedge core_clk)
    trim_mem_data <= {5'h14, trim_mem_addr} ^ trim_key;

  // Start pulses are counted because they pass inside a frame's tail.
  always @(posedge core_clk)
    if (meas_start === 1'b1)
      shots <= shots + 1;

  // Hang guard: the whole run needs under a thousand cycles.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [39:0] r;
    host.frame({1'b0, a}, d, r);
  endtask

  task automatic rc(input logic [6:0] a, input logic [39:0] exp);
    logic [39:0] r;
    host.frame({1'b1, a}, 8'h00, r);
    chk(r, exp);
  endtask

  // Route, then events; expected value is {output enable, pin level}.
  task automatic evc(input logic [7:0] rt, input logic [11:0] s,
    input logic [1:0] exp);
    wr(SC_ADDR_ROUTE, rt);
    @(posedge core_clk);
    ev <= s;
    repeat (3) @(posedge core_clk);
    #1 chk({event_pin_oe, pin_lvl}, exp);
  endtask

  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk(trim_value, 8'hA3);
    rc(SC_ADDR_RATE, 40'h0010000000);
    wr(SC_ADDR_ROUTE, 8'hFF);
    wr(SC_ADDR_FIFO, 8'hFF);
    wr(SC_ADDR_THR, 8'hFF);
    rc(SC_ADDR_ROUTE, 40'h3F0F7F0000);
    for (int i = 0; i < 8; i++)
    begin
      wr(SC_ADDR_FIFO, 8'(i));
      chk(fifo_mode, FM_EXP[i]);
    end
    wr(SC_ADDR_THR, 8'h05);
    wr(SC_ADDR_FIFO, 8'h08);
    evc(8'h10, 12'h005, 2'b11);
    chk(fifo_full, 1'b1);
    evc(8'h10, 12'h004, 2'b10);
    evc(8'h20, 12'h080, 2'b11);
    evc(8'h08, 12'h400, 2'b11);
    evc(8'h04, 12'h800, 2'b11);
    evc(8'h00, 12'hC80, 2'b10);
    evc(8'h0C, 12'hC00, 2'b11);
    chk(event_src, 2'h0);
    evc(8'h0C, 12'h400, 2'b11);
    chk(event_src, 2'h2);
    evc(8'h01, 12'h100, 2'b10);
    evc(8'h01, 12'h200, 2'b11);
    evc(8'h02, 12'h100, 2'b11);
    evc(8'h03, 12'h200, 2'b11);
    evc(8'h03, 12'h800, 2'b10);
    wr(SC_ADDR_CTRL, 8'h50);
    evc(8'h04, 12'h800, 2'b10);
    wr(SC_ADDR_CTRL, 8'h70);
    evc(8'h04, 12'h800, 2'b10);
    evc(8'h04, 12'h000, 2'b01);
    wr(SC_ADDR_CTRL, 8'h12);
    chk(low_noise_on, 1'b1);
    wr(SC_ADDR_RATE, 8'h60);
    chk(low_noise_on, 1'b0);
    wr(SC_ADDR_RATE, 8'h50);
    chk(low_noise_on, 1'b1);
    wr(SC_ADDR_CTRL, 8'h13);
    wr(SC_ADDR_RATE, 8'h00);
    rc(SC_ADDR_CTRL, 40'h1204080500);
    wr(SC_ADDR_CTRL, 8'h11);
    @(posedge core_clk);
    meas_done <= 1'b1;
    @(posedge core_clk);
    meas_done <= 1'b0;
    rc(SC_ADDR_CTRL, 40'h1004080500);
    chk(shots, 1);
    trim_key <= 8'h5A;
    wr(SC_ADDR_CTRL, 8'h90);
    chk({trim_ready, trim_value}, 9'h1A3);
    @(posedge core_clk);
    rate_tick <= 1'b1;
    @(posedge core_clk);
    rate_tick <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk(trim_value, 8'hF9);
    rc(SC_ADDR_CTRL, 40'h1004080500);
    @(posedge core_clk);
    ref_in <= 16'h8123;
    ref_load <= 1'b1;
    auto_f <= 2'h2;
    @(posedge core_clk);
    ref_load <= 1'b0;
    auto_f <= 2'h1;
    wr(SC_ADDR_REF_LOW_BITS, 8'hFF);
    rc(SC_ADDR_REF_LOW_BITS, 40'h2381000000);
    rc(SC_ADDR_FDAT, 40'hA1B2C3D4E5);
    wr(SC_ADDR_CTRL, 8'h00);
    rc(7'h79, 40'hB2B2B2B2B2);
    wr(SC_ADDR_CTRL, 8'h04);
    rc(SC_ADDR_RATE, 40'h0010000000);
    give_verdict();
  end
endmodule
